// ---- hdl/adcgs_pkg.sv ----
// constants for the converter control and gain select block
package adcgs_pkg;

    // ==========================================================
    // bus and register map
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_RES_HIGH  = 8'h04;
    localparam logic [7:0]  OFF_RES_LOW   = 8'h08;
    localparam logic [7:0]  OFF_GAIN      = 8'h0C;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ==========================================================
    // control register fields
    localparam int unsigned CTRL_BUSY     = 0;
    localparam int unsigned CTRL_PSC      = 1;
    localparam int unsigned CTRL_MUX      = 2;
    localparam int unsigned CTRL_MODE     = 3;
    localparam int unsigned CTRL_CH_LO    = 4;
    localparam int unsigned CTRL_CH_HI    = 7;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;

    // ==========================================================
    // gain register fields
    localparam int unsigned GAIN_CODE_LO  = 0;
    localparam int unsigned GAIN_CODE_HI  = 2;
    localparam int unsigned GAIN_TRIM     = 5;
    localparam int unsigned GAIN_TS_EN    = 6;
    localparam int unsigned GAIN_STANDALONE_AMPLIFIER_EN  = 7;
    localparam logic [7:0]  GAIN_WR_MASK  = 8'hE7;
    localparam logic [7:0]  GAIN_RESET    = 8'h00;

    // ==========================================================
    // result layout
    localparam int unsigned RES_W         = 10;
    localparam int unsigned RES_LOW_POS   = 6;

    // ==========================================================
    // channel codes
    localparam logic [3:0]  CH_TEMP       = 4'h7;
    localparam logic [3:0]  CH_UNUSED_A   = 4'h8;
    localparam logic [3:0]  CH_UNUSED_B   = 4'h9;
    localparam logic [3:0]  CH_FIRST_EXT  = 4'hA;
    localparam logic [3:0]  CH_PAIR_UNUSED = 4'hC;
    localparam logic [3:0]  CH_MUX_MINUS  = 4'hD;
    localparam logic [3:0]  CH_MUX_OUT    = 4'hE;
    localparam logic [3:0]  CH_ADC_IN     = 4'hF;
    localparam int unsigned NUM_CH        = 16;

    // ==========================================================
    // prescaler
    localparam int unsigned PSC_DIV_SLOW  = 16;
    localparam int unsigned PSC_CNT_W     = 4;
    localparam logic [3:0]  PSC_LAST      = 4'(PSC_DIV_SLOW - 1);

    typedef enum logic {ADCGS_IDLE, ADCGS_CONV} adcgs_state_t;

endpackage : adcgs_pkg

// ---- hdl/adcgs_sel_if.sv ----
// channel and amplifier selection carrier between control and decode
`timescale 1ns/10ps
interface adcgs_sel_if;
    logic [3:0]  chan_code;
    logic        diff;
    logic        mux;
    logic [2:0]  gain_code;
    logic        trim;
    logic        ts_en;
    logic        busy;
    logic [15:0] pos_en;
    logic [15:0] neg_en;
    logic        ts_sel;
    logic        mux_pin_en;
    logic        adin_pin_en;
    logic        pga_en;
    logic        pga_open;
    logic        chan_valid;

    modport ctrl (output chan_code, diff, mux, gain_code, trim, ts_en, busy,
                  input  pos_en, neg_en, ts_sel, mux_pin_en, adin_pin_en, pga_en, pga_open, chan_valid);
    modport dec  (input  chan_code, diff, mux, gain_code, trim, ts_en, busy,
                  output pos_en, neg_en, ts_sel, mux_pin_en, adin_pin_en, pga_en, pga_open, chan_valid);
endinterface : adcgs_sel_if

// ---- hdl/adcgs_prescale.sv ----
// converter clock prescaler, divide by one or sixteen
`timescale 1ns/10ps
module adcgs_prescale (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    input  wire logic run,
    input  wire logic div16,
    output logic      tick
);
    logic [adcgs_pkg::PSC_CNT_W-1:0] cnt_q;

    // ==========================================================
    // divider, held in reset while idle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
        end else if (ce) begin
            if (!run) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                tick <= 1'b0;
            end else if (div16) begin
                tick <= (cnt_q == adcgs_pkg::PSC_LAST);
            end else begin
                tick <= 1'b1;
            end
        end
    end
endmodule : adcgs_prescale

// ---- hdl/adcgs_decode.sv ----
// channel routing and amplifier configuration decode
`timescale 1ns/10ps
module adcgs_decode (
    adcgs_sel_if.dec s
);
    logic amp_on;
    logic path_on;

    always_comb begin
        amp_on        = s.trim | (s.gain_code != 3'h0);
        path_on       = s.busy | s.mux | amp_on;
        s.pga_en      = amp_on;
        s.pga_open    = s.trim;
        s.pos_en      = '0;
        s.neg_en      = '0;
        s.ts_sel      = 1'b0;
        s.chan_valid  = 1'b0;
        s.mux_pin_en  = s.mux & path_on;
        s.adin_pin_en = s.mux & path_on;
        if (s.chan_code == adcgs_pkg::CH_TEMP) begin
            if (!s.diff && !s.mux && s.ts_en) begin
                s.ts_sel     = path_on;
                s.chan_valid = 1'b1;
            end
        end else if (s.chan_code >= adcgs_pkg::CH_FIRST_EXT) begin
            s.chan_valid = 1'b1;
            if (s.mux && (s.chan_code == adcgs_pkg::CH_MUX_OUT || s.chan_code == adcgs_pkg::CH_ADC_IN)) begin
                s.chan_valid = 1'b0;
            end
            if (s.mux && s.diff && (s.chan_code == adcgs_pkg::CH_PAIR_UNUSED
                                    || s.chan_code == adcgs_pkg::CH_MUX_MINUS)) begin
                s.chan_valid = 1'b0;
            end
            if (s.chan_valid && path_on) begin
                s.pos_en[s.chan_code] = 1'b1;
                if (s.diff) begin
                    s.neg_en[{s.chan_code[3:1], ~s.chan_code[0]}] = 1'b1;
                end
            end
        end
    end
endmodule : adcgs_decode

// ---- hdl/adcgs_top.sv ----
// converter control and gain select with an AXI4-Lite register slave
// Behaviour
// - mux routing: 14 mux out, 15 converter in
// - routing on: no temperature sensor, 8/9 unused
// - mode 0 single-ended, 1 differential
// - prescaler 0 divides by 1, 1 by 16
// - idle busy stops prescaler and converter clock
// - writing busy one starts with current settings
// - completion clears busy, powers converter down
// - restart needs zero write then one write
// - idle gates channels unless routing or amplifier
// - result split high 9:2, low 1:0 top
// - results writable, unreset, loaded at completion
// - gain register fields, reset zero, reserved zero
// - gain code map, trim forces open loop
// - trim shorts amplifier inputs for trimming
// - control register field layout
// - reset clears control, converter powered down
// - channel and differential pair code map
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module adcgs_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             conv_clk_en,
    output logic             conv_power,
    output logic             conv_start,
    output logic             conv_abort,
    input  wire logic        conv_done,
    input  wire logic [9:0]  conv_data,
    output logic [15:0]      pos_chan_en,
    output logic [15:0]      neg_chan_en,
    output logic             temp_sensor_sel,
    output logic             temp_sensor_on,
    output logic             mux_out_pin_en,
    output logic             adc_in_pin_en,
    output logic             diff_mode,
    output logic             pga_enable,
    output logic             pga_open_loop,
    output logic [2:0]       pga_gain_code,
    output logic             standalone_amp_on
);
    adcgs_pkg::adcgs_state_t st_q;
    logic [7:0]  ctrl_q;
    logic [7:1]  snap_q;
    logic [7:0]  gain_q;
    logic [7:0]  res_high_q;
    logic [1:0]  res_low_q;
    logic        wr_fire;
    logic        rd_fire;
    logic        wr_ctrl;
    logic        busy;
    logic        start_req;
    logic        abort_req;
    logic        done_now;
    logic [7:0]  cfg;
    logic        psc_tick;
    logic [7:0]  rd_val;
    logic        rd_hit;
    logic        wr_hit;

    adcgs_sel_if sel ();

    // ==========================================================
    // write and read handshakes
    assign busy          = (st_q == adcgs_pkg::ADCGS_CONV);
    assign wr_fire       = ce & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign rd_fire       = ce & s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_arready = rd_fire;
    assign wr_ctrl       = wr_fire & s_axi_wstrb[0] & (s_axi_awaddr == adcgs_pkg::OFF_CTRL);
    assign start_req     = wr_ctrl & s_axi_wdata[adcgs_pkg::CTRL_BUSY] & ~busy;
    assign abort_req     = wr_ctrl & ~s_axi_wdata[adcgs_pkg::CTRL_BUSY] & busy;
    assign done_now      = busy & conv_done;

    always_comb begin
        wr_hit = 1'b1;
        if (s_axi_awaddr == adcgs_pkg::OFF_CTRL) begin
            wr_hit = 1'b1;
        end else if (s_axi_awaddr == adcgs_pkg::OFF_RES_HIGH) begin
            wr_hit = 1'b1;
        end else if (s_axi_awaddr == adcgs_pkg::OFF_RES_LOW) begin
            wr_hit = 1'b1;
        end else if (s_axi_awaddr == adcgs_pkg::OFF_GAIN) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= adcgs_pkg::RESP_OKAY;
        end else if (ce) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? adcgs_pkg::RESP_OKAY : adcgs_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // read mux
    always_comb begin
        rd_hit = 1'b1;
        rd_val = 8'h00;
        if (s_axi_araddr == adcgs_pkg::OFF_CTRL) begin
            rd_val = {ctrl_q[7:1], busy};
        end else if (s_axi_araddr == adcgs_pkg::OFF_RES_HIGH) begin
            rd_val = res_high_q;
        end else if (s_axi_araddr == adcgs_pkg::OFF_RES_LOW) begin
            rd_val = {res_low_q, 6'h00};
        end else if (s_axi_araddr == adcgs_pkg::OFF_GAIN) begin
            rd_val = gain_q;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= adcgs_pkg::RESP_OKAY;
        end else if (ce) begin
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h00_0000, rd_val};
                s_axi_rresp  <= rd_hit ? adcgs_pkg::RESP_OKAY : adcgs_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // control register and conversion state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= adcgs_pkg::CTRL_RESET;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl_q <= s_axi_wdata[7:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= adcgs_pkg::ADCGS_IDLE;
        end else if (ce) begin
            case (st_q)
                adcgs_pkg::ADCGS_IDLE: begin
                    if (start_req) begin
                        st_q <= adcgs_pkg::ADCGS_CONV;
                    end
                end
                adcgs_pkg::ADCGS_CONV: begin
                    if (abort_req) begin
                        st_q <= adcgs_pkg::ADCGS_IDLE;
                    end else if (conv_done) begin
                        st_q <= adcgs_pkg::ADCGS_IDLE;
                    end
                end
                default: begin
                    st_q <= adcgs_pkg::ADCGS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            snap_q <= 7'h00;
        end else if (ce) begin
            if (start_req) begin
                snap_q <= s_axi_wdata[7:1];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_start <= 1'b0;
            conv_abort <= 1'b0;
        end else if (ce) begin
            conv_start <= start_req;
            conv_abort <= abort_req;
        end
    end

    // ==========================================================
    // gain register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gain_q <= adcgs_pkg::GAIN_RESET;
        end else if (ce) begin
            if (wr_fire && s_axi_wstrb[0] && s_axi_awaddr == adcgs_pkg::OFF_GAIN) begin
                gain_q <= s_axi_wdata[7:0] & adcgs_pkg::GAIN_WR_MASK;
            end
        end
    end

    // ==========================================================
    // result registers, no reset
    always_ff @(posedge aclk) begin
        if (ce) begin
            if (done_now) begin
                res_high_q <= conv_data[9:2];
                res_low_q  <= conv_data[1:0];
            end else if (wr_fire && s_axi_wstrb[0]) begin
                if (s_axi_awaddr == adcgs_pkg::OFF_RES_HIGH) begin
                    res_high_q <= s_axi_wdata[7:0];
                end else if (s_axi_awaddr == adcgs_pkg::OFF_RES_LOW) begin
                    res_low_q <= s_axi_wdata[7:6];
                end
            end
        end
    end

    // ==========================================================
    // selection decode, live settings while idle
    assign cfg           = busy ? {snap_q, 1'b1} : {ctrl_q[7:1], 1'b0};
    assign sel.chan_code = cfg[adcgs_pkg::CTRL_CH_HI:adcgs_pkg::CTRL_CH_LO];
    assign sel.diff      = cfg[adcgs_pkg::CTRL_MODE];
    assign sel.mux       = cfg[adcgs_pkg::CTRL_MUX];
    assign sel.gain_code = gain_q[adcgs_pkg::GAIN_CODE_HI:adcgs_pkg::GAIN_CODE_LO];
    assign sel.trim      = gain_q[adcgs_pkg::GAIN_TRIM];
    assign sel.ts_en     = gain_q[adcgs_pkg::GAIN_TS_EN];
    assign sel.busy      = busy;

    adcgs_decode u_decode (
        .s (sel.dec)
    );

    adcgs_prescale u_prescale (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .run     (busy),
        .div16   (snap_q[adcgs_pkg::CTRL_PSC]),
        .tick    (psc_tick)
    );

    // ==========================================================
    // registered analog controls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_clk_en       <= 1'b0;
            conv_power        <= 1'b0;
            pos_chan_en       <= 16'h0000;
            neg_chan_en       <= 16'h0000;
            temp_sensor_sel   <= 1'b0;
            temp_sensor_on    <= 1'b0;
            mux_out_pin_en    <= 1'b0;
            adc_in_pin_en     <= 1'b0;
            diff_mode         <= 1'b0;
            pga_enable        <= 1'b0;
            pga_open_loop     <= 1'b0;
            pga_gain_code     <= 3'h0;
            standalone_amp_on <= 1'b0;
        end else if (ce) begin
            conv_clk_en       <= psc_tick & busy & ~done_now & ~abort_req;
            conv_power        <= (busy & ~done_now & ~abort_req) | start_req;
            pos_chan_en       <= sel.pos_en;
            neg_chan_en       <= sel.neg_en;
            temp_sensor_sel   <= sel.ts_sel;
            temp_sensor_on    <= sel.ts_en;
            mux_out_pin_en    <= sel.mux_pin_en;
            adc_in_pin_en     <= sel.adin_pin_en;
            diff_mode         <= sel.diff;
            pga_enable        <= sel.pga_en;
            pga_open_loop     <= sel.pga_open;
            pga_gain_code     <= sel.gain_code;
            standalone_amp_on <= gain_q[adcgs_pkg::GAIN_STANDALONE_AMPLIFIER_EN];
        end
    end
endmodule : adcgs_top

// ---- sim/adcgs_chk.sv ----
// port assertions for the converter control and gain select block
`timescale 1ns/10ps
module adcgs_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        conv_clk_en,
    input wire logic        conv_power,
    input wire logic        conv_start,
    input wire logic        conv_abort,
    input wire logic        conv_done,
    input wire logic [15:0] pos_chan_en,
    input wire logic [15:0] neg_chan_en
);
    // ==========================================================
    // helpers
    logic       take_w, ctrl_w, start_w, psc_q, diff_q, mux_q, seen_q;
    logic [3:0] ch_q;
    logic [4:0] cnt_q;
    assign take_w  = ce && s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready;
    assign ctrl_w  = take_w && s_axi_awaddr == adcgs_pkg::OFF_CTRL && s_axi_wstrb[0];
    assign start_w = ctrl_w && s_axi_wdata[0] && !conv_power;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {ch_q, diff_q, mux_q, psc_q} <= 7'h00;
        end else if (start_w) begin
            {ch_q, diff_q, mux_q, psc_q} <= s_axi_wdata[7:1];
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || !conv_power) begin
            cnt_q  <= 5'h00;
            seen_q <= 1'b0;
        end else if (conv_clk_en) begin
            cnt_q  <= 5'h00;
            seen_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 5'h01;
        end
    end
    // ==========================================================
    // assertions
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_start_pulse: assert property (start_w |=> conv_start && conv_power)
        else $error("no start pulse after start write");
    a_busy_ignore: assert property (ctrl_w && s_axi_wdata[0] && conv_power && !conv_done |=> !conv_start)
        else $error("start write while busy restarted");
    a_abort_pulse: assert property (ctrl_w && !s_axi_wdata[0] && conv_power && !conv_done |=>
        conv_abort && !conv_power) else $error("zero write did not abort");
    a_done_clears: assert property (ce && conv_power && conv_done |=> !conv_power && !conv_clk_en)
        else $error("converter still powered after done");
    a_idle_no_clk: assert property (!conv_power |-> !conv_clk_en)
        else $error("converter clock while idle");
    a_div1_tick: assert property (conv_power && $past(conv_power) && $past(conv_power, 2) && !psc_q |->
        conv_clk_en) else $error("divide by one missed a tick");
    a_div16_gap: assert property (conv_power && psc_q |->
        (conv_clk_en ? (cnt_q == (seen_q ? 5'h0F : 5'h11)) : (cnt_q <= 5'h11))) else $error("divide by sixteen spacing");
    a_chan_map: assert property (conv_power && $past(conv_power) && !conv_abort && !mux_q && ch_q >= 4'hA |->
        pos_chan_en == (16'h0001 << ch_q) && neg_chan_en == (diff_q ? (16'h0001 << (ch_q ^ 4'h1)) : 16'h0000))
        else $error("channel gates do not match snapshot");
    a_write_answer: assert property (take_w |=> s_axi_bvalid)
        else $error("write not answered");
    a_unmapped_err: assert property (take_w && !(s_axi_awaddr inside {8'h00, 8'h04, 8'h08, 8'h0C}) |=>
        s_axi_bresp == adcgs_pkg::RESP_SLVERR) else $error("unmapped write not refused");
    c_start: cover property (start_w);
    c_abort: cover property (ctrl_w && !s_axi_wdata[0] && conv_power);
    c_done: cover property (conv_power && conv_done);
endmodule : adcgs_chk
bind adcgs_top adcgs_chk i_adcgs_chk (.*);

// ---- sim/adcgs_core_model.sv ----
// converter core model: counts clock ticks, then reports a result
`timescale 1ns/10ps
module adcgs_core_model (
    input  wire logic       aclk,
    input  wire logic       conv_clk_en,
    input  wire logic       conv_start,
    input  wire logic       conv_abort,
    input  wire logic [4:0] ticks,
    input  wire logic [9:0] value,
    output logic            conv_done,
    output logic [9:0]      conv_data
);
    int n = -1;
    initial begin
        conv_done = 1'b0;
        conv_data = 10'h000;
    end
    always @(posedge aclk) begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (conv_start || conv_abort) begin
            n <= conv_start ? int'(ticks) : -1;
        end else if (n == 0) begin
            conv_done <= 1'b1;
            conv_data <= value;
            n <= -1;
        end else if (n > 0 && conv_clk_en) begin
            n <= n - 1;
        end
    end
endmodule : adcgs_core_model

// ---- sim/test_adc_control_and_gain_select.sv ----
// self-checking bench for the converter control and gain select block
`timescale 1ns/10ps
module test_adc_control_and_gain_select;
    // ==========================================================
    // signals
    logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        conv_clk_en, conv_power, conv_start, conv_abort, conv_done, diff_mode;
    logic [9:0]  conv_data, value = 10'h000;
    logic [15:0] pos_chan_en, neg_chan_en;
    logic        temp_sensor_sel, temp_sensor_on, mux_out_pin_en, adc_in_pin_en;
    logic        pga_enable, pga_open_loop, standalone_amp_on;
    logic [2:0]  pga_gain_code;
    logic [4:0]  ticks = 5'h02;
    int          mismatches = 0, checked = 0, cycles = 0, gain_m = 0, cfg;
    adcgs_top i_adcgs_top (.*);
    adcgs_core_model i_adcgs_core_model (.aclk(aclk), .conv_clk_en(conv_clk_en), .conv_start(conv_start),
        .conv_abort(conv_abort), .ticks(ticks), .value(value), .conv_done(conv_done), .conv_data(conv_data));
    always #20 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end
    // ==========================================================
    // tasks
    task automatic wrap_up();
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awprot <= 3'($urandom);
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arprot <= 3'($urandom);
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        got = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask : rd
    task automatic conv(input logic [7:0] c, input logic [4:0] t);
        ticks <= t;
        value <= 10'($urandom);
        wr(8'h00, {24'h0, c | 8'h01});
        rd(8'h00);
        cmp(got[0], 1'b1);
        cmp(temp_sensor_sel, c == 8'h70);
        cmp(diff_mode, c[3]);
        for (int i = 0; i < 200 && got[0] !== 1'b0; i++) begin
            rd(8'h00);
        end
        rd(8'h04);
        cmp(got, value[9:2]);
        rd(8'h08);
        cmp(got, {value[1:0], 6'h00});
        rd(8'h00);
        cmp(got, c);
    endtask : conv
    task automatic route(input logic [7:0] c, input logic [15:0] p, input logic [1:0] pins);
        wr(8'h00, 32'(c));
        @(negedge aclk);
        cmp(pos_chan_en, p);
        cmp({mux_out_pin_en, adc_in_pin_en, temp_sensor_sel}, {pins, 1'b0});
    endtask : route
    // ==========================================================
    // sequence
    initial begin
        void'($urandom(32'hD7FEB20A));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00);
        cmp(got, 32'h0);
        rd(8'h0C);
        cmp(got, 32'h0);
        wr(8'h04, 32'h1A5);
        rd(8'h04);
        cmp(got, 32'hA5);
        wr(8'h08, 32'hFF);
        rd(8'h08);
        cmp(got, 32'hC0);
        for (int i = 0; i < 12; i++) begin
            cfg = $urandom;
            s_axi_wstrb <= 4'($urandom);
            wr(8'h0C, cfg);
            gain_m = s_axi_wstrb[0] ? cfg & 32'hE7 : gain_m;
            rd(8'h0C);
            cmp(got, gain_m);
            cmp({pga_enable, pga_open_loop, pga_gain_code}, {gain_m[5] | (gain_m[2:0] != 0), gain_m[5:5], gain_m[2:0]});
            cmp({standalone_amp_on, temp_sensor_on}, gain_m[7:6]);
        end
        s_axi_wstrb <= 4'hF;
        wr(8'h0C, 32'h0);
        for (int i = 0; i < 24; i++) begin
            conv(8'(((10 + i % 6) << 4) | ((i / 6 % 2) << 3) | ((i / 12) << 1)), 5'(2 + i % 3));
        end
        wr(8'h0C, 32'h41);
        repeat (10) @(posedge aclk);
        conv(8'h70, 5'd3);
        wr(8'h0C, 32'h0);
        ticks <= 5'd20;
        wr(8'h00, 32'hA7);
        wr(8'h00, 32'hF1);
        rd(8'h00);
        cmp(got, 32'hF1);
        cmp({mux_out_pin_en, adc_in_pin_en}, 2'b11);
        wr(8'h00, 32'hF0);
        conv(8'hB8, 5'd3);
        wr(8'h0C, 32'h40);
        route(8'hA4, 16'h0400, 2'b11);
        route(8'hE4, 16'h0000, 2'b11);
        route(8'h74, 16'h0000, 2'b11);
        route(8'h94, 16'h0000, 2'b11);
        route(8'hCC, 16'h0000, 2'b11);
        route(8'hA0, 16'h0000, 2'b00);
        wr(8'h0C, 32'h41);
        route(8'hB0, 16'h0800, 2'b00);
        wr(8'h10, 32'h1);
        cmp(rsp, adcgs_pkg::RESP_SLVERR);
        rd(8'h10);
        cmp(got, 32'h0);
        cmp(rsp, adcgs_pkg::RESP_SLVERR);
        ce <= 1'b0;
        fork
            wr(8'h04, 32'h5A);
        join_none
        repeat (6) @(posedge aclk);
        cmp(s_axi_bvalid, 1'b0);
        ce <= 1'b1;
        wait fork;
        rd(8'h04);
        cmp(got, 32'h5A);
        wrap_up();
    end
endmodule : test_adc_control_and_gain_select
